// [hw/uapf_top.sv]
// Auto-open UDP port, source address filter and reinitialization control.
`timescale 1ns/10ps
`default_nettype none
`include "uapf_defines.svh"
// How it works
// - After a good initial process the auto port opens from stored settings.
// - The auto port closes only on station reset or power loss.
// - The auto port takes requests from any permitted source addressed to this device.
// - One auto port request at a time; later requests wait until done.
// - A new auto port number is used only after a reinitialization.
// - New filter words take effect only when a reinitialization completes.
// - Completing a reinitialization clears the denial monitoring words.
// - Every access, any connection, is judged by the active filter.
// - The reinit instruction applies the held filter words like the bit.
// - Setting bit 1 picks binary or ASCII message coding.
// - Setting bit 4 picks echo or keepalive peer liveness checking.
// - Setting bit 5 picks Ethernet II or IEEE 802.3 framing.
// - Setting bit 6 allows or refuses remote writes while running.
// - Setting bit 8 picks open waiting and communication while stopped.
// - Host sets bit 15 to ask; device clears it when finished.
// - Initial and reinitial results go to the error code word.
// - Filter enable word and allow or deny type word.
// - Eight entries of start and end address; zero means single or unused.
// - Denials counted, wrapping to one, and last denied address kept.
module uapf_top (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 host_wr,
	input  wire logic                 host_rd,
	input  wire logic          [15:0] host_addr,
	input  wire logic          [15:0] host_wdata,
	output logic               [15:0] host_rdata,
	output logic                      host_rvalid,
	input  wire logic                 reinit_instruction,
	input  wire logic          [15:0] proc_fault_code,
	input  wire logic                 cpu_running,
	input  wire logic                 acc_valid,
	input  wire logic          [31:0] acc_src_ip,
	input  wire logic                 acc_to_auto,
	input  wire logic                 acc_dst_self,
	input  wire logic          [15:0] acc_dst_port,
	input  wire logic                 acc_is_write,
	output logic                      acc_ready,
	output logic                      acc_grant,
	output logic                      acc_deny,
	output logic                      acc_block,
	input  wire logic                 auto_done,
	output logic                      init_done_flag,
	output logic                      auto_port_open,
	output logic                      auto_port_busy,
	output logic               [15:0] auto_port_num,
	output logic                      ascii_mode,
	output logic                      keepalive_mode,
	output logic                      ieee8023_frame,
	output logic                      run_write_enable,
	output logic                      open_wait
);
	// ==================================================================
	// Address decode helpers.
	function automatic logic in_range(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [5:0] flt_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - `UAPF_ADDR_FLT_FIRST;
		return d[5:0];
	endfunction

	// ==================================================================
	// State.
	uapf_pkg::uapf_state_e state;
	uapf_pkg::uapf_state_e next_state;
	logic [15:0] cycle_cnt;
	logic [15:0] opset;
	logic [15:0] err_code;
	logic [15:0] port_staged;
	logic [15:0] flt_staged [0:`UAPF_FLT_WORDS-1];
	logic [15:0] flt_active [0:`UAPF_FLT_WORDS-1];
	logic        finish;
	logic        good_end;
	logic        reinit_req;
	logic        host_wr_op;
	logic        permit;
	logic        mon_clr;
	logic        taken;
	logic        auto_hit;
	logic        mode_refuse;
	uapf_pkg::uapf_ip_t deny_count;
	uapf_pkg::uapf_ip_t deny_last;

	// ==================================================================
	// Sequencer control terms.
	assign finish     = (state != uapf_pkg::UAPF_ST_RUN) &&
		(cycle_cnt == 16'(`UAPF_INIT_CYCLES - 1));
	assign good_end   = finish && (proc_fault_code == `UAPF_WORD_ZERO);
	assign host_wr_op = host_wr && (host_addr == `UAPF_ADDR_OPSET);
	assign reinit_req = opset[`UAPF_OP_REINIT] || reinit_instruction;
	assign mon_clr    = finish && (state == uapf_pkg::UAPF_ST_REINIT);

	// Next state of the initial and reinitial sequencer.
	always_comb begin
		next_state = state;
		case (state)
			uapf_pkg::UAPF_ST_INIT: begin
				if (finish) begin
					next_state = uapf_pkg::UAPF_ST_RUN;
				end
			end
			uapf_pkg::UAPF_ST_RUN: begin
				if (reinit_req) begin
					next_state = uapf_pkg::UAPF_ST_REINIT;
				end
			end
			uapf_pkg::UAPF_ST_REINIT: begin
				if (finish) begin
					next_state = uapf_pkg::UAPF_ST_RUN;
				end
			end
			default: begin
				next_state = uapf_pkg::UAPF_ST_INIT;
			end
		endcase
	end

	// State register and process duration counter.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state     <= uapf_pkg::UAPF_ST_INIT;
			cycle_cnt <= 16'h0000;
		end else begin
			state <= next_state;
			if (state == uapf_pkg::UAPF_ST_RUN || finish) begin
				cycle_cnt <= 16'h0000;
			end else begin
				cycle_cnt <= cycle_cnt + 16'h0001;
			end
		end
	end

	// ==================================================================
	// Operation setting word; the host's set wins over the device clear.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			opset <= `UAPF_OPSET_RESET;
		end else if (host_wr_op) begin
			opset <= host_wdata & `UAPF_OP_MASK;
		end else if (mon_clr) begin
			opset[`UAPF_OP_REINIT] <= 1'b0;
		end
	end

	// Result of each initial and reinitial process.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			err_code <= `UAPF_WORD_ZERO;
		end else if (finish) begin
			err_code <= proc_fault_code;
		end
	end

	// Initial done flag stays low during a reinitialization.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			init_done_flag <= 1'b0;
		end else if (finish) begin
			init_done_flag <= good_end;
		end else if (state == uapf_pkg::UAPF_ST_REINIT) begin
			init_done_flag <= 1'b0;
		end
	end

	// ==================================================================
	// Staged settings written by the host.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			port_staged <= `UAPF_AUTOPORT_RESET;
			for (int i = 0; i < `UAPF_FLT_WORDS; i++) begin
				flt_staged[i] <= `UAPF_WORD_ZERO;
			end
		end else if (host_wr) begin
			if (host_addr == `UAPF_ADDR_AUTOPORT) begin
				port_staged <= host_wdata;
			end else if (in_range(host_addr, `UAPF_ADDR_FLT_FIRST,
				`UAPF_ADDR_FLT_LAST)) begin
				flt_staged[flt_idx(host_addr)] <= host_wdata;
			end
		end
	end

	// Active copies change only at a good end of a process.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			auto_port_num <= `UAPF_AUTOPORT_RESET;
			for (int i = 0; i < `UAPF_FLT_WORDS; i++) begin
				flt_active[i] <= `UAPF_WORD_ZERO;
			end
		end else if (good_end) begin
			auto_port_num <= port_staged;
			for (int i = 0; i < `UAPF_FLT_WORDS; i++) begin
				flt_active[i] <= flt_staged[i];
			end
		end
	end

	// Decoded operating modes, taken from the setting word at a good end.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ascii_mode       <= 1'b0;
			keepalive_mode   <= 1'b0;
			ieee8023_frame   <= 1'b0;
			run_write_enable <= 1'b0;
			open_wait        <= 1'b0;
		end else if (good_end) begin
			ascii_mode       <= opset[`UAPF_OP_ASCII];
			keepalive_mode   <= opset[`UAPF_OP_KEEPALIVE];
			ieee8023_frame   <= opset[`UAPF_OP_IEEE8023];
			run_write_enable <= opset[`UAPF_OP_RUNWRITE];
			open_wait        <= opset[`UAPF_OP_OPENWAIT];
		end
	end

	// ==================================================================
	// Auto port opens at the first good initial end and stays open.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			auto_port_open <= 1'b0;
		end else if (good_end && state == uapf_pkg::UAPF_ST_INIT) begin
			auto_port_open <= 1'b1;
		end
	end

	// ==================================================================
	// Access handling: filter first, then mode refusal, then auto port.
	uapf_ip_filter u_filter (
		.cfg    (flt_active),
		.ip     (acc_src_ip),
		.permit (permit)
	);

	assign taken       = acc_valid && (!acc_to_auto || acc_ready);
	assign mode_refuse = (cpu_running && acc_is_write && !run_write_enable)
		|| (!cpu_running && !open_wait);
	assign auto_hit    = acc_to_auto && auto_port_open && acc_dst_self &&
		(acc_dst_port == auto_port_num);

	// One-cycle verdict pulses for a taken access; a permitted, unrefused auto port request that misses the port gets none.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			acc_grant <= 1'b0;
			acc_deny  <= 1'b0;
			acc_block <= 1'b0;
		end else begin
			acc_deny  <= taken && !permit;
			acc_block <= taken && permit && mode_refuse;
			acc_grant <= taken && permit && !mode_refuse &&
				(!acc_to_auto || auto_hit);
		end
	end

	// Auto port stays occupied from a granted request until it is done.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			auto_port_busy <= 1'b0;
		end else if (taken && permit && !mode_refuse && auto_hit) begin
			auto_port_busy <= 1'b1;
		end else if (auto_done) begin
			auto_port_busy <= 1'b0;
		end
	end

	// Ready for auto port requests only while the port is idle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			acc_ready <= 1'b0;
		end else begin
			acc_ready <= !(taken && permit && !mode_refuse && auto_hit) &&
				(!auto_port_busy || auto_done);
		end
	end

	uapf_deny_mon u_mon (
		.clk     (clk),
		.rstn    (rstn),
		.clr     (mon_clr),
		.deny    (taken && !permit),
		.deny_ip (acc_src_ip),
		.count   (deny_count),
		.last_ip (deny_last)
	);

	// ==================================================================
	// Host read port: data one cycle after the strobe, zero if unmapped.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			host_rdata  <= `UAPF_WORD_ZERO;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			if (!host_rd) begin
				host_rdata <= host_rdata;
			end else if (host_addr == `UAPF_ADDR_OPSET) begin
				host_rdata <= opset;
			end else if (host_addr == `UAPF_ADDR_ERRCODE) begin
				host_rdata <= err_code;
			end else if (host_addr == `UAPF_ADDR_AUTOPORT) begin
				host_rdata <= port_staged;
			end else if (in_range(host_addr, `UAPF_ADDR_FLT_FIRST,
				`UAPF_ADDR_FLT_LAST)) begin
				host_rdata <= flt_staged[flt_idx(host_addr)];
			end else if (host_addr == `UAPF_ADDR_MON_FIRST) begin
				host_rdata <= deny_count[15:0];
			end else if (host_addr == `UAPF_ADDR_MON_FIRST + 16'h0001) begin
				host_rdata <= deny_count[31:16];
			end else if (host_addr == `UAPF_ADDR_MON_FIRST + 16'h0002) begin
				host_rdata <= deny_last[15:0];
			end else if (host_addr == `UAPF_ADDR_MON_LAST) begin
				host_rdata <= deny_last[31:16];
			end else begin
				host_rdata <= `UAPF_WORD_ZERO;
			end
		end
	end
endmodule
`default_nettype wire

// [hw/uapf_defines.svh]
// Offsets, field positions, reset values and timing counts of the block.
`ifndef UAPF_DEFINES_SVH
`define UAPF_DEFINES_SVH
// ==========================================================================
// Word addresses of the shared buffer memory.
`define UAPF_ADDR_OPSET      16'h001F
`define UAPF_ADDR_ERRCODE    16'h0069
`define UAPF_ADDR_AUTOPORT   16'h0020
`define UAPF_ADDR_FLT_FIRST  16'h5700
`define UAPF_ADDR_FLT_LAST   16'h5721
`define UAPF_ADDR_MON_FIRST  16'h5722
`define UAPF_ADDR_MON_LAST   16'h5725
`define UAPF_FLT_WORDS       34
`define UAPF_FLT_ENTRIES     8
// ==========================================================================
// Bit positions of the operation setting word.
`define UAPF_OP_ASCII        1
`define UAPF_OP_KEEPALIVE    4
`define UAPF_OP_IEEE8023     5
`define UAPF_OP_RUNWRITE     6
`define UAPF_OP_OPENWAIT     8
`define UAPF_OP_REINIT       15
`define UAPF_OP_MASK         16'h8172
// ==========================================================================
// Reset values.
`define UAPF_OPSET_RESET     16'h0000
`define UAPF_AUTOPORT_RESET  16'h1388
`define UAPF_WORD_ZERO       16'h0000
`define UAPF_CNT_MAX         32'hFFFFFFFF
`define UAPF_CNT_ONE         32'h00000001
// ==========================================================================
// Timing: the initial and reinitial processes each last a fixed time.
`define UAPF_CLK_PERIOD_NS   5
`define UAPF_INIT_TIME_NS    1000
`define UAPF_INIT_CYCLES     ((`UAPF_INIT_TIME_NS+`UAPF_CLK_PERIOD_NS-1)/`UAPF_CLK_PERIOD_NS)
`endif

// [hw/uapf_pkg.sv]
// Types shared by the files of the block.
package uapf_pkg;
	// ==================================================================
	// Sequencer states.
	typedef enum logic [1:0] {
		UAPF_ST_INIT   = 2'b00,
		UAPF_ST_RUN    = 2'b01,
		UAPF_ST_REINIT = 2'b10
	} uapf_state_e;
	typedef logic [15:0] uapf_word_t;
	typedef logic [31:0] uapf_ip_t;
endpackage

// [hw/uapf_ip_filter.sv]
// Allow or deny decision on a source address from the active filter words.
`timescale 1ns/10ps
`default_nettype none
`include "uapf_defines.svh"
module uapf_ip_filter (
	input  wire logic              [15:0] cfg [0:`UAPF_FLT_WORDS-1],
	input  wire uapf_pkg::uapf_ip_t       ip,
	output logic                          permit
);
	// ==================================================================
	// Entry match: zero start is unused, zero end is a single address.
	function automatic logic entry_hit(input logic [31:0] st,
		input logic [31:0] en, input logic [31:0] a);
		logic hit;
		hit = 1'b0;
		if (st != 32'h00000000) begin
			if (en == 32'h00000000) begin
				hit = (a == st);
			end else begin
				hit = (a >= st) && (a <= en);
			end
		end
		return hit;
	endfunction

	logic listed;

	// Entries are scanned, then the type word turns a hit into a verdict.
	always_comb begin
		listed = 1'b0;
		for (int i = 0; i < `UAPF_FLT_ENTRIES; i++) begin
			listed = listed | entry_hit({cfg[4*i+3], cfg[4*i+2]},
				{cfg[4*i+5], cfg[4*i+4]}, ip);
		end
		if (!cfg[0][0]) begin
			permit = 1'b1;
		end else if (!cfg[1][0]) begin
			permit = listed;
		end else begin
			permit = !listed;
		end
	end
endmodule
`default_nettype wire

// [hw/uapf_deny_mon.sv]
// Denied access counter and last denied source address.
`timescale 1ns/10ps
`default_nettype none
`include "uapf_defines.svh"
module uapf_deny_mon (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire logic                     clr,
	input  wire logic                     deny,
	input  wire uapf_pkg::uapf_ip_t       deny_ip,
	output uapf_pkg::uapf_ip_t            count,
	output uapf_pkg::uapf_ip_t            last_ip
);
	// ==================================================================
	// A denial in the clearing cycle is kept, so it counts as the first.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			count <= 32'h00000000;
		end else if (deny) begin
			if (clr || count == `UAPF_CNT_MAX) begin
				count <= `UAPF_CNT_ONE;
			end else begin
				count <= count + `UAPF_CNT_ONE;
			end
		end else if (clr) begin
			count <= 32'h00000000;
		end
	end

	// The latest denied address is held until the next clear.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			last_ip <= 32'h00000000;
		end else if (deny) begin
			last_ip <= deny_ip;
		end else if (clr) begin
			last_ip <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// [verif/uapf_checker.sv]
// Concurrent checks on the ports of the block top.
`timescale 1ns/10ps
`default_nettype none
module uapf_checker (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        host_wr,
	input wire logic        host_rd,
	input wire logic [15:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic        host_rvalid,
	input wire logic        cpu_running,
	input wire logic        acc_valid,
	input wire logic        acc_to_auto,
	input wire logic        acc_is_write,
	input wire logic        acc_ready,
	input wire logic        acc_grant,
	input wire logic        acc_deny,
	input wire logic        acc_block,
	input wire logic        auto_done,
	input wire logic        init_done_flag,
	input wire logic        auto_port_open,
	input wire logic        auto_port_busy,
	input wire logic [15:0] auto_port_num,
	input wire logic        ascii_mode,
	input wire logic        keepalive_mode,
	input wire logic        ieee8023_frame,
	input wire logic        run_write_enable,
	input wire logic        open_wait
);
	// ========
	// Assertions, all in the one clock domain.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_read_answer: assert property (host_rd |=> host_rvalid)
		else $error("read strobe without answer");
	a_one_outcome: assert property (
		$onehot0({acc_grant, acc_deny, acc_block}))
		else $error("several access outcomes at once");
	a_busy_on_grant: assert property ($rose(auto_port_busy) |-> acc_grant)
		else $error("auto port busy without a grant");
	a_idle_after_done: assert property (auto_port_busy && auto_done
		|=> !auto_port_busy && acc_ready) else $error("auto port stays busy");
	a_port_stays_open: assert property (auto_port_open |=> auto_port_open)
		else $error("auto port closed while running");
	a_open_at_init: assert property (
		$rose(auto_port_open) |-> $rose(init_done_flag))
		else $error("auto port opened outside a good initial end");
	a_num_on_reinit: assert property (
		$changed(auto_port_num) |-> $rose(init_done_flag))
		else $error("port number changed outside a good process end");
	a_modes_on_end: assert property (
		$changed({ascii_mode, keepalive_mode, ieee8023_frame,
		run_write_enable, open_wait}) |-> $rose(init_done_flag))
		else $error("mode changed outside a good process end");
	a_stopped_block: assert property (
		acc_valid && !acc_to_auto && !cpu_running && !open_wait
		|=> acc_block || acc_deny) else $error("stopped access let through");
	a_run_write_block: assert property (
		acc_valid && !acc_to_auto && cpu_running && acc_is_write
		&& !run_write_enable |=> acc_block || acc_deny)
		else $error("remote write let through while running");
	a_reinit_drop: assert property (init_done_flag && host_wr
		&& host_addr == 16'h001F && host_wdata[15] |-> ##[1:3] !init_done_flag)
		else $error("reinit request did not drop the done flag");
	c_auto_grant: cover property (acc_grant && auto_port_busy);
	c_deny: cover property (acc_deny);
	c_block: cover property (acc_block);
endmodule
bind uapf_top uapf_checker u_chk (.clk, .rstn, .host_wr, .host_rd, .host_addr,
	.host_wdata, .host_rvalid, .cpu_running, .acc_valid, .acc_to_auto,
	.acc_is_write, .acc_ready, .acc_grant, .acc_deny, .acc_block, .auto_done,
	.init_done_flag, .auto_port_open, .auto_port_busy, .auto_port_num,
	.ascii_mode, .keepalive_mode, .ieee8023_frame, .run_write_enable,
	.open_wait);
`default_nettype wire

// [verif/uapf_far_model.sv]
// Far side model that finishes auto port requests after a set delay.
`timescale 1ns/10ps
`default_nettype none
module uapf_far_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       busy,
	input  wire logic [7:0] delay,
	output logic            done
);
	logic [7:0] cnt;
	// Counts busy cycles and ends the request once, when the delay has run.
	always_ff @(posedge clk) begin
		if (!rstn || !busy) begin
			cnt <= 8'h00;
			done <= 1'b0;
		end else begin
			cnt <= cnt + 8'h01;
			done <= (cnt == delay);
		end
	end
endmodule
`default_nettype wire

// [verif/tb_uapf_top.sv]
// Self-checking bench of the auto port, filter and reinit block.
`timescale 1ns/10ps
`default_nettype none
module tb_uapf_top;
	logic        clk, rstn, host_wr, host_rd, reinit_instruction;
	logic        cpu_running, acc_valid, acc_to_auto, acc_dst_self;
	logic        acc_is_write, auto_done, host_rvalid, acc_ready;
	logic        acc_grant, acc_deny, acc_block, init_done_flag;
	logic        auto_port_open, auto_port_busy, ascii_mode, open_wait;
	logic        keepalive_mode, ieee8023_frame, run_write_enable;
	logic [15:0] host_addr, host_wdata, host_rdata, proc_fault_code;
	logic [15:0] acc_dst_port, auto_port_num, op, act_op, port_st, port_act;
	logic [31:0] acc_src_ip, s_lo, f_lo, ip_a, ip_b, last_ip;
	logic [7:0]  far_delay;
	logic        s_en, s_ty, f_en, f_ty;
	int          miscompares, checks, n;
	// Source addresses the filter should have denied since the last clear.
	logic [31:0] denied [$];
	uapf_top dut (.clk, .rstn, .host_wr, .host_rd, .host_addr, .host_wdata,
		.host_rdata, .host_rvalid, .reinit_instruction, .proc_fault_code,
		.cpu_running, .acc_valid, .acc_src_ip, .acc_to_auto, .acc_dst_self,
		.acc_dst_port, .acc_is_write, .acc_ready, .acc_grant, .acc_deny,
		.acc_block, .auto_done, .init_done_flag, .auto_port_open,
		.auto_port_busy, .auto_port_num, .ascii_mode, .keepalive_mode,
		.ieee8023_frame, .run_write_enable, .open_wait);
	uapf_far_model far (.clk, .rstn, .busy(auto_port_busy), .delay(far_delay),
		.done(auto_done));
	always #2.5 clk = ~clk;
	// ========
	// Comparison, bus and access tasks.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= v;
		@(posedge clk);
		host_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clk);
		host_rd <= 1'b0;
		#1;
		chk({host_rvalid, host_rdata}, {1'b1, e});
	endtask
	// Drives one access, waits for a free auto port, checks the outcome.
	task automatic acc(input logic [31:0] ip, input logic au, s, w, r);
		logic [2:0] e;
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_src_ip <= ip;
		acc_to_auto <= au;
		acc_dst_self <= s;
		acc_is_write <= w;
		cpu_running <= r;
		acc_dst_port <= port_act;
		n = 0;
		@(negedge clk);
		while (au && acc_ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (f_en && ((ip == f_lo) == f_ty)) e = 3'b010;
		else if (r ? (w && !act_op[6]) : !act_op[8]) e = 3'b001;
		else if (au && !s) e = 3'b000;
		else e = 3'b100;
		if (e == 3'b010) begin
			denied.push_back(ip);
		end
		@(posedge clk);
		acc_valid <= 1'b0;
		#1;
		chk({acc_grant, acc_deny, acc_block}, e);
	endtask
	task automatic wflt(input logic en, ty, input logic [31:0] lo);
		chk(init_done_flag, 1'b1);
		s_en = en;
		s_ty = ty;
		s_lo = lo;
		wr(16'h5700, {15'h0000, en});
		wr(16'h5701, {15'h0000, ty});
		wr(16'h5702, lo[15:0]);
		wr(16'h5703, lo[31:16]);
	endtask
	// Requests a reinit by bit or by instruction and checks its results.
	task automatic reinit(input logic ins, input logic [15:0] f);
		@(posedge clk);
		proc_fault_code <= f;
		if (ins) begin
			@(posedge clk);
			reinit_instruction <= 1'b1;
			@(posedge clk);
			reinit_instruction <= 1'b0;
		end else begin
			wr(16'h001F, op | 16'h8000);
		end
		repeat (210) @(posedge clk);
		if (f == 16'h0000) begin
			act_op = op;
			port_act = port_st;
			f_en = s_en;
			f_ty = s_ty;
			f_lo = s_lo;
		end
		denied.delete();
		rdc(16'h001F, op);
		rdc(16'h0069, f);
		rdc(16'h5722, 16'h0000);
		rdc(16'h5724, 16'h0000);
		chk(init_done_flag, f == 16'h0000);
		chk(auto_port_num, port_act);
		chk({open_wait, run_write_enable, ieee8023_frame, keepalive_mode,
			ascii_mode}, {act_op[8], act_op[6:4], act_op[1]});
	endtask
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ========
	// Main sequence.
	initial begin
		{clk, rstn, host_wr, host_rd, reinit_instruction, acc_valid} = 6'h00;
		{acc_to_auto, acc_dst_self, acc_is_write, cpu_running} = 4'h1;
		{host_addr, host_wdata, proc_fault_code, acc_dst_port} = 64'h0;
		{acc_src_ip, s_lo, f_lo, last_ip, op, act_op} = 160'h0;
		{s_en, s_ty, f_en, f_ty, miscompares, checks} = 68'h0;
		port_act = 16'h1388;
		far_delay = 8'd20;
		void'($urandom(32'h6d0a237b));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (205) @(posedge clk);
		chk({init_done_flag, auto_port_open}, 2'b11);
		rdc(16'h0069, 16'h0000);
		rdc(16'h001F, 16'h0000);
		rdc(16'h1234, 16'h0000);
		wr(16'h0069, 16'hFFFF);
		rdc(16'h0069, 16'h0000);
		op = 16'($urandom) & 16'h0172;
		wr(16'h001F, op | 16'h0E8D);
		rdc(16'h001F, op);
		port_st = 16'($urandom);
		wr(16'h0020, port_st);
		chk(auto_port_num, 16'h1388);
		ip_a = {8'hC0, 24'($urandom)};
		ip_b = ip_a ^ 32'h00000100;
		wflt(1'b1, 1'b0, ip_a);
		acc(ip_b, 1'b0, 1'b1, 1'b0, 1'b1);
		reinit(1'b0, 16'h0000);
		acc(ip_b, 1'b0, 1'b1, 1'b0, 1'b1);
		acc(ip_b, 1'b0, 1'b1, 1'b1, 1'b0);
		last_ip = denied[denied.size()-1];
		rdc(16'h5722, 16'(denied.size()));
		rdc(16'h5723, 16'h0000);
		rdc(16'h5724, last_ip[15:0]);
		rdc(16'h5725, last_ip[31:16]);
		for (int i = 0; i < 4; i++) begin
			acc(ip_a, 1'b0, 1'b1, i[1], i[0]);
		end
		acc(ip_a, 1'b1, 1'b1, 1'b0, 1'b1);
		acc(ip_a, 1'b1, 1'b1, 1'b0, 1'b1);
		chk(n > 10, 1'b1);
		far_delay <= 8'd1;
		acc(ip_a, 1'b1, 1'b0, 1'b0, 1'b1);
		wflt(1'b0, 1'b0, ip_a);
		reinit(1'b1, 16'($urandom) | 16'h0001);
		acc(ip_b, 1'b0, 1'b1, 1'b0, 1'b1);
		reinit(1'b1, 16'h0000);
		acc(ip_b, 1'b0, 1'b1, 1'b0, 1'b1);
		chk(auto_port_open, 1'b1);
		// A station reset in mid-run closes the port until a new good start.
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		chk({auto_port_open, init_done_flag}, 2'b00);
		chk(auto_port_num, 16'h1388);
		rstn <= 1'b1;
		repeat (205) @(posedge clk);
		chk(auto_port_open, 1'b1);
		print_verdict();
	end
	initial begin
		#50000;
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
